/* File: hw/async_serial_transceiver.v */
`timescale 1ns/10ps
// Operation
// - idle transmit line rests at mark
// - start, eight or nine data, stop
// - each bit lasts one bit period
// - baud generator, 8-bit or 16-bit divider
// - data bits least significant first
// - tx and rx independent, shared rate; ninth-bit select per direction
// - no hardware parity; ninth bit only
// - transmitter needs enable, async, port enable
// - port enable drives transmit pin output
// - empty flag sets when transmit enabled
// - buffer write starts, moves if shifter empty
// - queued char loads one cycle after stop bit begins
// - polarity bit inverts idle and data
// - empty clear only when busy and queued
// - empty flag valid two cycles after write
// - empty flag read-only
// - flag independent of enable; irq gated
// - port enable bit 7; clear holds reset
// - continuous enable runs receiver; single ignored
// - single enable self-clears in synchronous master
// - address detect in nine-bit mode loads only when bit8 set; eight-bit mode loads all
`include "serial_consts.vh"
module async_serial_transceiver (
  input  wire        clock,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rxPin,
  output reg         txPinOut,
  output reg         txPinOe,
  output reg         txInterrupt
);
  reg [7:0] baudCtl_q;
  reg [7:0] rxCtl_q;
  reg [7:0] divLo_q;
  reg [7:0] divHi_q;
  reg [7:0] txCtl_q;
  reg [7:0] rxData_q;
  reg       rxBit8_q;
  reg       framing_error_flag_q;
  reg       overrun_error_flag_q;
  reg       rxFull_q;
  reg       transmit_interrupt_enable_q;
  reg [8:0] txBuf_q;
  reg [8:0] tsr_q;
  reg       txBufFull_q;
  reg       tsrBusy_q;
  reg [1:0] flagDelay_q;
  reg       txEmpty_q;
  reg [1:0] rxSync_q;

  wire portEn   = rxCtl_q[`RS_PORT_EN];
  // port enable clear holds every engine in reset
  wire portRst  = reset | ~portEn;
  // synchronous mode is not built; selecting it idles the transmitter and, as master, lets single receive self-clear
  wire txActive = txCtl_q[`TS_TRANSMIT_ENABLE] & ~txCtl_q[`TS_SYNC] & portEn;
  wire rxOn     = rxCtl_q[`RS_CONT] & portEn;
  wire nine     = rxCtl_q[`RS_RX9];
  wire txNine   = txCtl_q[`TS_TX9];
  wire access   = psel & penable;
  wire wr       = access & pwrite;
  wire rd       = access & ~pwrite;
  wire setupCyc = psel & ~penable;

  ////////////////////////////////////////////////////////////////
  // baud tick generator, shared by both directions
  reg [15:0] divCnt_q;
  reg [5:0]  preCnt_q;
  reg        tick_q;
  wire [15:0] divisor = baudCtl_q[`BC_WIDE] ?
                        {divHi_q, divLo_q} :
                        {8'h00, divLo_q};
  // sixteen ticks a bit: the slow setting spends four divider periods a tick, the
  // fastest cannot go below one divider period a tick and so runs like the middle one
  reg  [5:0]  preLim;
  wire [5:0]  subLim  = preLim >> 4;
  always @* begin
    case ({txCtl_q[`TS_HIGHSPEED], baudCtl_q[`BC_WIDE]})
      2'b00:   preLim = `PRE_LOW;
      2'b01:   preLim = `PRE_MID;
      2'b10:   preLim = `PRE_MID;
      default: preLim = `PRE_FAST;
    endcase
  end
  always @(posedge clock) begin
    if (portRst) begin
      divCnt_q  <= 16'h0000;
      preCnt_q  <= 6'h00;
      tick_q    <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (divCnt_q >= divisor) begin
        divCnt_q <= 16'h0000;
        if (preCnt_q >= subLim) begin
          preCnt_q <= 6'h00;
          tick_q   <= 1'b1;
        end else begin
          preCnt_q <= preCnt_q + 6'h01;
        end
      end else begin
        divCnt_q <= divCnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // transmitter
  localparam TX_IDLE = 2'h0, TX_START = 2'h1, TX_DATA = 2'h2, TX_STOP = 2'h3;
  reg [1:0] txState_q;
  reg [4:0] txSub_q;
  reg [3:0] txBit_q;
  reg       txLine_q;
  wire      bufWrite = wr & (paddr == `OFF_TRANSMIT_DATA);
  wire      bitEnd   = tick_q & (txSub_q == `SAMPLES - 5'h01);
  wire [3:0] txLast  = txNine ? 4'h8 : 4'h7;
  // queued char moves one cycle after stop begins
  reg       stopBegan_q;
  reg       reloaded_q;
  always @(posedge clock) begin
    if (portRst | ~txActive) begin
      txState_q   <= TX_IDLE;
      txSub_q     <= 5'h00;
      txBit_q     <= 4'h0;
      txLine_q    <= 1'b1;
      tsr_q       <= 9'h000;
      tsrBusy_q   <= 1'b0;
      txBufFull_q <= 1'b0;
      txBuf_q     <= 9'h000;
      stopBegan_q <= 1'b0;
      reloaded_q  <= 1'b0;
    end else begin
      stopBegan_q <= 1'b0;
      if (tick_q)
        txSub_q <= (txSub_q == `SAMPLES - 5'h01) ? 5'h00 : txSub_q + 5'h01;
      if (bufWrite) begin
        txBuf_q     <= {txCtl_q[`TS_BIT8], pwdata[7:0]};
        txBufFull_q <= 1'b1;
      end
      case (txState_q)
        TX_IDLE: begin
          txLine_q <= 1'b1;
          // start on a tick so the start bit is a whole bit long
          if (txBufFull_q & tick_q) begin
            tsr_q       <= txBuf_q;
            tsrBusy_q   <= 1'b1;
            txBufFull_q <= bufWrite;
            txState_q   <= TX_START;
            txSub_q     <= 5'h00;
            txLine_q    <= 1'b0;
          end
        end
        TX_START: begin
          if (bitEnd) begin
            txState_q <= TX_DATA;
            txBit_q   <= 4'h0;
            txLine_q  <= tsr_q[0];
          end
        end
        TX_DATA: begin
          if (bitEnd) begin
            if (txBit_q == txLast) begin
              txState_q   <= TX_STOP;
              txLine_q    <= 1'b1;
              stopBegan_q <= 1'b1;
            end else begin
              txBit_q  <= txBit_q + 4'h1;
              tsr_q    <= {1'b0, tsr_q[8:1]};
              txLine_q <= tsr_q[1];
            end
          end
        end
        TX_STOP: begin
          if (stopBegan_q & txBufFull_q & ~bufWrite) begin
            tsr_q       <= txBuf_q;
            txBufFull_q <= 1'b0;
            reloaded_q  <= 1'b1;
          end
          // a character reloaded at stop begin starts right after this stop bit; a later one waits in idle for a tick
          if (bitEnd) begin
            reloaded_q <= 1'b0;
            if (reloaded_q) begin
              txState_q <= TX_START;
              txLine_q  <= 1'b0;
            end else begin
              tsrBusy_q <= 1'b0;
              txState_q <= TX_IDLE;
            end
          end
        end
        default: txState_q <= TX_IDLE;
      endcase
    end
  end

  // empty flag follows buffer state with a two-cycle settle
  always @(posedge clock) begin
    if (portRst) begin
      flagDelay_q <= 2'h0;
      txEmpty_q   <= 1'b0;
    end else begin
      if (bufWrite)
        // reads inside the settle window still show the old state
        flagDelay_q <= `FLAG_DELAY;
      else if (flagDelay_q != 2'h0)
        flagDelay_q <= flagDelay_q - 2'h1;
      if (flagDelay_q == 2'h0 || flagDelay_q == 2'h1)
        txEmpty_q <= txActive & ~(txBufFull_q & tsrBusy_q);
    end
  end

  ////////////////////////////////////////////////////////////////
  // receiver
  localparam RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h2, RX_STOP = 2'h3;
  reg [1:0] rxState_q;
  reg [4:0] rxSub_q;
  reg [3:0] rxBit_q;
  reg [8:0] rsr_q;
  wire      rxIn     = rxSync_q[1];
  wire      rxSample = tick_q & (rxSub_q == `MID_SAMPLE);
  wire [3:0] rxLast  = nine ? 4'h8 : 4'h7;
  wire      bufRead  = rd & (paddr == `OFF_RECEIVE_DATA);
  always @(posedge clock) begin
    // mark preset: no false start edge right after reset
    if (reset)
      rxSync_q <= 2'h3;
    else
      rxSync_q <= {rxSync_q[0], rxPin};
  end

  // accept rule for a completed frame
  wire [8:0] rxWord  = nine ? rsr_q : {1'b0, rsr_q[8:1]};
  wire       accept  = ~(nine & rxCtl_q[`RS_ADDR]) | rsr_q[8];
  always @(posedge clock) begin
    if (portRst | ~rxOn) begin
      rxState_q <= RX_IDLE;
      rxSub_q   <= 5'h00;
      rxBit_q   <= 4'h0;
      rsr_q     <= 9'h000;
      overrun_error_flag_q    <= 1'b0;
      // a switched-off receiver keeps its last character readable
      if (portRst) begin
        rxFull_q <= 1'b0;
        rxData_q <= `RST_BYTE;
        rxBit8_q <= 1'b0;
        framing_error_flag_q   <= 1'b0;
      end else begin
        rxFull_q <= rxFull_q & ~bufRead;
      end
    end else begin
      if (bufRead)
        rxFull_q <= 1'b0;
      if (tick_q)
        rxSub_q <= (rxSub_q == `SAMPLES - 5'h01) ? 5'h00 : rxSub_q + 5'h01;
      case (rxState_q)
        RX_IDLE: begin
          if (~rxIn) begin
            rxState_q <= RX_START;
            rxSub_q   <= 5'h00;
          end
        end
        RX_START: begin
          if (rxSample)
            rxState_q <= rxIn ? RX_IDLE : RX_DATA;
          rxBit_q <= 4'h0;
        end
        RX_DATA: begin
          if (rxSample) begin
            rsr_q <= {rxIn, rsr_q[8:1]};
            if (rxBit_q == rxLast)
              rxState_q <= RX_STOP;
            else
              rxBit_q <= rxBit_q + 4'h1;
          end
        end
        RX_STOP: begin
          if (rxSample) begin
            rxState_q <= RX_IDLE;
            if (accept) begin
              // overrun drops the new character, the old one stays
              if (rxFull_q & ~bufRead)
                overrun_error_flag_q <= 1'b1;
              else begin
                rxData_q <= rxWord[7:0];
                rxBit8_q <= rxWord[8];
                framing_error_flag_q   <= ~rxIn;
                rxFull_q <= 1'b1;
              end
            end
          end
        end
        default: rxState_q <= RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // registers and APB slave, zero-wait
  // the eight mapped offsets only; anything else, aligned or not, answers with an error
  wire       decOk = (paddr == `OFF_BAUD_CONTROL) |
                     (paddr == `OFF_RECEIVE_DATA) |
                     (paddr == `OFF_RX_STATUS_CTRL) |
                     (paddr == `OFF_DIVISOR_LOW) |
                     (paddr == `OFF_DIVISOR_HIGH) |
                     (paddr == `OFF_TX_STATUS_CTRL) |
                     (paddr == `OFF_TRANSMIT_DATA) |
                     (paddr == `OFF_FLAGS);
  reg  [7:0] rdByte;
  always @* begin
    case (paddr)
      `OFF_BAUD_CONTROL:   rdByte = baudCtl_q;
      `OFF_RECEIVE_DATA:   rdByte = rxData_q;
      `OFF_RX_STATUS_CTRL: rdByte = {rxCtl_q[7:3], framing_error_flag_q, overrun_error_flag_q, rxBit8_q};
      `OFF_DIVISOR_LOW:    rdByte = divLo_q;
      `OFF_DIVISOR_HIGH:   rdByte = divHi_q;
      `OFF_TX_STATUS_CTRL: rdByte = {txCtl_q[7:2], ~tsrBusy_q, txCtl_q[0]};
      `OFF_FLAGS:          rdByte = {5'h00, rxFull_q, transmit_interrupt_enable_q, txEmpty_q};
      default:             rdByte = 8'h00;
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      baudCtl_q   <= `RST_BYTE;
      rxCtl_q     <= `RST_BYTE;
      divLo_q     <= `RST_BYTE;
      divHi_q     <= `RST_BYTE;
      txCtl_q     <= `RST_TX_STAT;
      transmit_interrupt_enable_q      <= 1'b0;
      prdata      <= 32'h00000000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      txPinOut    <= 1'b1;
      txPinOe     <= 1'b0;
      txInterrupt <= 1'b0;
    end else begin
      // read data latched in setup, so ready can answer in the first access cycle
      pready  <= setupCyc;
      pslverr <= setupCyc & ~decOk;
      if (setupCyc & ~pwrite)
        prdata <= {24'h000000, rdByte};
      // writes land only at the access edge
      if (wr & pready & decOk) begin
        case (paddr)
          `OFF_BAUD_CONTROL:   baudCtl_q <= pwdata[7:0] & 8'h18;
          `OFF_RX_STATUS_CTRL: rxCtl_q   <= {pwdata[7:3], 3'h0};
          `OFF_DIVISOR_LOW:    divLo_q   <= pwdata[7:0];
          `OFF_DIVISOR_HIGH:   divHi_q   <= pwdata[7:0];
          `OFF_TX_STATUS_CTRL: txCtl_q   <= {pwdata[7:2], 1'b0, pwdata[0]};
          `OFF_FLAGS:          transmit_interrupt_enable_q    <= pwdata[`FL_TRANSMIT_INTERRUPT_ENABLE];
          default:             transmit_interrupt_enable_q    <= transmit_interrupt_enable_q;
        endcase
      end
      // synchronous master single receive self-clears when idle
      if (txCtl_q[`TS_SYNC] & txCtl_q[`TS_MASTER] & rxCtl_q[`RS_SINGLE] &
          rxState_q == RX_IDLE & ~rxOn)
        rxCtl_q[`RS_SINGLE] <= 1'b0;
      txPinOe     <= portEn;
      // polarity applied last, so the shift path never sees it
      txPinOut    <= txLine_q ^ baudCtl_q[`BC_POLARITY];
      txInterrupt <= txEmpty_q & transmit_interrupt_enable_q;
    end
  end
endmodule

/* File: hw/serial_consts.vh */
`ifndef SERIAL_CONSTS_VH
`define SERIAL_CONSTS_VH
// register byte offsets
`define OFF_BAUD_CONTROL   12'h000
`define OFF_RECEIVE_DATA   12'h004
`define OFF_RX_STATUS_CTRL 12'h008
`define OFF_DIVISOR_LOW    12'h00c
`define OFF_DIVISOR_HIGH   12'h010
`define OFF_TX_STATUS_CTRL 12'h014
`define OFF_TRANSMIT_DATA  12'h018
`define OFF_FLAGS          12'h01c
// receive_status_control fields
`define RS_PORT_EN   7
`define RS_RX9       6
`define RS_SINGLE    5
`define RS_CONT      4
`define RS_ADDR      3
`define RS_FRAMING_ERROR_FLAG      2
`define RS_OVERRUN_ERROR_FLAG      1
`define RS_BIT8      0
// transmit_status_control fields
`define TS_MASTER    7
`define TS_TX9       6
`define TS_TRANSMIT_ENABLE      5
`define TS_SYNC      4
`define TS_HIGHSPEED 2
`define TS_SHIFT_REGISTER_EMPTY      1
`define TS_BIT8      0
// baud_control fields
`define BC_POLARITY  4
`define BC_WIDE      3
// flag register fields
`define FL_TXEMPTY   0
`define FL_TRANSMIT_INTERRUPT_ENABLE      1
`define FL_RXFULL    2
// reset values
`define RST_BYTE     8'h00
`define RST_TX_STAT  8'h02
// divider prescales: baud tick = clock/((prescale/16+1)*(n+1)), fraction dropped
`define PRE_LOW      6'h3f
`define PRE_MID      6'h0f
`define PRE_FAST     6'h03
`define MID_SAMPLE   5'h07
`define SAMPLES      5'h10
`define FLAG_DELAY   2'h2
`endif

/* File: tb/async_serial_transceiver_bench.sv */
`timescale 1ns/10ps
module async_serial_transceiver_bench;
  localparam int BIT = 32;
  logic        clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, rxPin, txPinOut, txPinOe, txInterrupt;
  int          errors = 0, n_compared = 0;
  always #4 clock = ~clock;
  async_serial_transceiver u_async_serial_transceiver (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxPin(rxPin), .txPinOut(txPinOut), .txPinOe(txPinOe), .txInterrupt(txInterrupt));
  remote_uart #(.BIT(BIT)) u_remote_uart (.clock(clock), .lineIn(txPinOut), .lineOut(rxPin));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic waitRx(input int k);
    while (u_remote_uart.rxQ.size() < k) begin
      @(posedge clock);
    end
  endtask
  task close_out;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    xfer(12'h008, 0, 0); chk(rd, 32'h00);
    xfer(12'h014, 0, 0); chk(rd, 32'h02);
    xfer(12'h020, 0, 0); chk(er, 32'h1);
    chk(rd, 32'h0);
    // wide divider at normal speed: 32 clocks a bit
    xfer(12'h000, 1, 32'h08);
    xfer(12'h00c, 1, 32'h01);
    xfer(12'h010, 1, 32'h00);
    xfer(12'h008, 1, 32'h90);
    @(posedge clock);
    chk(txPinOe, 32'h1);
    xfer(12'h014, 1, 32'h20);
    xfer(12'h01c, 0, 0); chk(rd, 32'h01);
    xfer(12'h01c, 1, 32'h02);
    @(posedge clock);
    chk(txInterrupt, 32'h1);
    xfer(12'h01c, 1, 32'h00);
    @(posedge clock);
    chk(txInterrupt, 32'h0);
    xfer(12'h01c, 0, 0); chk(rd, 32'h01);
    xfer(12'h018, 1, 32'ha5);
    xfer(12'h018, 1, 32'h3c);
    // the flag is only valid from the second cycle after the write
    repeat (2) @(posedge clock);
    xfer(12'h01c, 0, 0); chk(rd, 32'h00);
    xfer(12'h014, 0, 0); chk(rd, 32'h20);
    waitRx(2);
    chk(u_remote_uart.rxQ.pop_front(), 32'ha5);
    chk(u_remote_uart.rxQ.pop_front(), 32'h3c);
    repeat (BIT) @(posedge clock);
    xfer(12'h014, 0, 0); chk(rd, 32'h22);
    u_remote_uart.sendByte(8'h5a, 1'b1);
    repeat (4) @(posedge clock);
    xfer(12'h01c, 0, 0); chk(rd, 32'h05);
    xfer(12'h004, 0, 0); chk(rd, 32'h5a);
    u_remote_uart.sendByte(8'h33, 1'b0);
    repeat (4) @(posedge clock);
    xfer(12'h008, 0, 0); chk(rd, 32'h94);
    xfer(12'h004, 0, 0); chk(rd, 32'h33);
    xfer(12'h000, 1, 32'h18);
    @(posedge clock);
    chk(txPinOut, 32'h0);
    // idle long enough that the inverted rest is not taken for a frame
    repeat (1400) @(posedge clock);
    xfer(12'h000, 1, 32'h08);
    @(posedge clock);
    chk(txPinOut, 32'h1);
    u_remote_uart.rxQ.delete();
    xfer(12'h008, 1, 32'h00);
    @(posedge clock);
    chk(txPinOe, 32'h0);
    close_out;
  end
  initial begin
    repeat (30000) @(posedge clock);
    errors++;
    close_out;
  end
endmodule

/* File: tb/remote_uart.sv */
`timescale 1ns/10ps
module remote_uart #(
  parameter int BIT = 128
) (
  input wire logic clock,
  input wire logic lineIn,
  output logic     lineOut
);
  logic [7:0] rxQ[$];
  initial lineOut = 1'b1;
  task automatic sendByte(input logic [7:0] d, input logic stopLvl);
    logic [9:0] f;
    f = {stopLvl, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      lineOut <= f[i];
      repeat (BIT) @(posedge clock);
    end
    // line idles at mark between frames
    lineOut <= 1'b1;
  endtask
  initial begin
    logic [7:0] d;
    forever begin
      @(negedge lineIn);
      repeat (BIT / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clock);
        d[i] = lineIn;
      end
      repeat (BIT) @(posedge clock);
      if (lineIn)
        rxQ.push_back(d);
    end
  end
endmodule

/* File: tb/serial_asserts.sv */
`timescale 1ns/10ps
module serial_asserts #(
  parameter int BIT = 32
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxPin,
  input wire logic        txPinOut,
  input wire logic        txPinOe,
  input wire logic        txInterrupt
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic        lastLvl;
  logic [11:0] runLen;
  // saturate so idle stretches never wrap into a fake bit length
  always @(posedge clock) begin
    lastLvl <= txPinOut;
    if (reset || !txPinOe || txPinOut != lastLvl)
      runLen <= 12'h001;
    else if (runLen != 12'hfff)
      runLen <= runLen + 12'h001;
  end
  sequence setupPh;
    psel && !penable;
  endsequence
  sequence accessPh;
    psel && penable;
  endsequence
  wire rsWrite = psel && penable && pready && pwrite && paddr == 12'h008;
  wire flWrite = psel && penable && pready && pwrite && paddr == 12'h01c;
  ////////////////////////////////////////
  AST_BIT_TIME: assert property (txPinOe && txPinOut && !lastLvl && runLen < 10 * BIT |->
    runLen % BIT == 0) else $error("low run not whole bits");
  AST_OE_ON: assert property (rsWrite && pwdata[7] |-> ##[1:2] txPinOe)
    else $error("pin not driven after enable");
  AST_OE_OFF: assert property (rsWrite && !pwdata[7] |-> ##[1:2] !txPinOe)
    else $error("pin still driven after disable");
  AST_RESET_IDLE: assert property ($fell(reset) |-> txPinOut && !txPinOe && !txInterrupt)
    else $error("outputs not idle after reset");
  AST_IRQ_OFF: assert property (flWrite && !pwdata[1] |-> ##[1:2] !txInterrupt)
    else $error("irq despite mask");
  AST_READY_FIRST: assert property (setupPh ##1 accessPh |-> pready)
    else $error("no ready in first access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_UNMAPPED: assert property (pready && !pwrite && paddr > 12'h01c |-> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
  AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule
bind async_serial_transceiver serial_asserts u_serial_asserts (.clock(clock), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxPin(rxPin), .txPinOut(txPinOut), .txPinOe(txPinOe), .txInterrupt(txInterrupt));
